// File: rtl/aof_formatter.sv
// Converter back end: dc offset loop, coding, overrange and output muxing
// Overview of operation
// - Cancel dc offset, range limited to 10 mV
// - Enabled loop updates and subtracts every cycle
// - Four-bit selector, 2^20 to 2^31 cycles
// - Hold freezes estimate, still applied
// - Off after reset until enabled and programmed
// - 14 or 12 bit samples, aligned clock
// - Interface chosen by register or strap
// - Double rate puts two bits per pair
// - Even bits on falling, odd on rising
// - Parallel mode: one bit per pin
// - Overrange high while input overloaded
// - Positive overload gives 3FFF or 1FFF
// - Negative overload gives 0000 or 2000
// - Coding chosen by register or strap
// - Strap levels map to coding and interface
// - Output enable pin gates data buffers
// - Serial data pin acts as standby control in strap mode
// - Output 21 cycles after sampling edge
`timescale 1ns/1ps
`default_nettype none
module aof_formatter #(
    parameter int DW = 14                    // Sample width, 14 or 12
) (
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire logic signed [DW-1:0]  sample_in,
    input  wire logic                  sample_over_pos,
    input  wire logic                  sample_over_neg,
    input  wire logic [1:0]            format_interface_strap,
    input  wire logic                  output_enable_pin,
    input  wire logic                  serial_data_in,
    input  wire logic                  serial_select_n,
    input  wire logic [3:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic [31:0]                avs_readdata,
    output logic                       avs_waitrequest,
    output logic [DW-1:0]              sample_data,
    output logic [DW/2-1:0]            ddr_pair,
    output logic                       forwarded_clock_true,
    output logic                       forwarded_clock_comp,
    output logic                       forwarded_clock_single,
    output logic                       data_oe,
    output logic                       overrange_flag,
    output logic                       standby
);
    // Accumulator wide enough for the longest time constant
    localparam int TC_W = aof_pkg::TC_BASE_LOG2 + 12;
    localparam int AW = DW + TC_W;
    // Correction limit in codes; integer rounding keeps it inside the range
    localparam int DC_LIM = aof_pkg::DC_LIMIT_MV * (1 << DW) / aof_pkg::FS_MVPP;
    localparam logic signed [DW-1:0] LIM_P = DC_LIM[DW-1:0];
    localparam logic signed [DW-1:0] LIM_N = -LIM_P;
    // Extreme codes in twos complement
    localparam logic signed [DW-1:0] MAXC = {1'b0, {(DW-1){1'b1}}};
    localparam logic signed [DW-1:0] MINC = {1'b1, {(DW-1){1'b0}}};

    // Delay line word: overload flags above the sample
    typedef logic [DW+1:0] aof_word_t;

    // Whole state of the block
    typedef struct packed {
        logic [4:0]              sync1;  // Pin synchroniser, first stage
        logic [4:0]              sync2;  // Pin synchroniser, second stage
        logic                    ack;    // Bus answer cycle
        logic [31:0]             rdata;  // Bus read data
        logic [4:0]              ctrl;   // Control bits
        logic [3:0]              tc;     // Time constant selector
        logic                    tc_set; // Selector written since reset
        logic signed [AW-1:0]    acc;    // Loop integrator
        aof_word_t [aof_pkg::LATENCY-1:0] dly; // Sample pipeline
        logic [DW-1:0]           q;      // Coded output sample
        logic                    o_ovr;  // Output overrange
        logic                    o_pos;  // Output clipped high
        logic                    o_ob;   // Output coded offset binary
        logic                    o_par;  // Output interface parallel
    } aof_state_t;

    aof_state_t s_r;                     // Registered state
    aof_state_t s_nxt;                   // Next state

    // Synchronised pins
    logic [1:0]              strap_s;    // Decoded strap level
    logic                    oe_s;       // Output enable pin
    logic                    sdi_s;      // Standby control pin
    logic                    sen_s;      // Serial select, high when idle
    // Effective modes and loop signals
    logic                    use_strap;  // Pins decide the modes
    logic                    eff_ob;     // Offset binary coding
    logic                    eff_par;    // Parallel interface
    logic                    stby;       // Standby in force
    logic                    active;     // Loop running
    logic signed [DW-1:0]    est;        // Clamped offset estimate
    logic signed [AW-1:0]    est_full;   // Unclamped estimate
    aof_word_t               tail;       // Sample leaving the delay line
    logic signed [DW:0]      diff;       // Sample minus estimate
    logic [DW-1:0]           code;       // Twos complement result
    logic                    bus_req;    // Request awaiting an answer

    assign strap_s   = s_r.sync2[4:3];
    assign oe_s      = s_r.sync2[2];
    assign sdi_s     = s_r.sync2[1];
    assign sen_s     = s_r.sync2[0];
    assign use_strap = s_r.ctrl[aof_pkg::CTRL_STRAP];

    // Saturate a widened value into the sample range
    function automatic logic [DW-1:0] sat(input logic signed [DW:0] v);
        // Casts keep both compares signed; a bare concatenation is unsigned
        if (v > signed'({MAXC[DW-1], MAXC}))
            sat = MAXC;
        else if (v < signed'({MINC[DW-1], MINC}))
            sat = MINC;
        else
            sat = v[DW-1:0];
    endfunction

    // Mode selection from strap or register
    always_comb
    begin
        if (use_strap)
        begin
            // Ground and 3/8 give twos complement; 3/8 and 5/8 are parallel
            eff_ob  = (strap_s == aof_pkg::STRAP_5_8) || (strap_s == aof_pkg::STRAP_AVDD);
            eff_par = (strap_s == aof_pkg::STRAP_3_8) || (strap_s == aof_pkg::STRAP_5_8);
        end
        else
        begin
            eff_ob  = s_r.ctrl[aof_pkg::CTRL_OB];
            eff_par = s_r.ctrl[aof_pkg::CTRL_PAR];
        end
        // Pin standby only counts with the serial port idle
        stby = use_strap && sen_s && sdi_s;
    end

    // Offset estimate from the integrator
    always_comb
    begin
        active   = s_r.ctrl[aof_pkg::CTRL_EN] && s_r.tc_set;
        est_full = signed'(s_r.acc) >>> (aof_pkg::TC_BASE_LOG2 + int'(s_r.tc));
        // Clamp to the correction range
        if (!active)
            est = '0;
        else if (est_full > AW'(LIM_P))
            est = LIM_P;
        else if (est_full < AW'(LIM_N))
            est = LIM_N;
        else
            est = est_full[DW-1:0];
        tail = s_r.dly[aof_pkg::LATENCY-1];
        diff = {tail[DW-1], tail[DW-1:0]} - {est[DW-1], est};
        code = sat(diff);
    end

    // Next state
    always_comb
    begin
        s_nxt = s_r;
        // Two-stage capture of the pins
        s_nxt.sync1 = {format_interface_strap, output_enable_pin,
                       serial_data_in, serial_select_n};
        s_nxt.sync2 = s_r.sync1;
        // Answer every request in the cycle after it appears
        bus_req   = (avs_read || avs_write) && !s_r.ack;
        s_nxt.ack = bus_req;
        if (bus_req)
        begin
            s_nxt.rdata = '0;
            if (!avs_read)
                s_nxt.rdata = '0;
            else if (avs_address == aof_pkg::REG_CTRL)
                s_nxt.rdata[4:0] = s_r.ctrl;
            else if (avs_address == aof_pkg::REG_TC)
                s_nxt.rdata[3:0] = s_r.tc;
            else if (avs_address == aof_pkg::REG_STATUS)
            begin
                s_nxt.rdata[aof_pkg::STAT_ACT]  = active;
                s_nxt.rdata[aof_pkg::STAT_OVR]  = s_r.o_ovr;
                s_nxt.rdata[aof_pkg::STAT_STBY] = stby;
                s_nxt.rdata[aof_pkg::STAT_PAR]  = eff_par;
                s_nxt.rdata[aof_pkg::STAT_OB]   = eff_ob;
                s_nxt.rdata[31:16] = 16'(est);
            end
        end
        // Writes land on the edge where waitrequest is low
        if (avs_write && s_r.ack && avs_byteenable[0])
        begin
            if (avs_address == aof_pkg::REG_CTRL)
                s_nxt.ctrl = avs_writedata[4:0];
            else if (avs_address == aof_pkg::REG_TC)
            begin
                s_nxt.tc     = avs_writedata[3:0];
                s_nxt.tc_set = 1'b1;
            end
        end
        // Sample pipeline
        s_nxt.dly = {s_r.dly[aof_pkg::LATENCY-2:0],
                     {sample_over_pos, sample_over_neg, sample_in}};
        // Integrator: cleared when off, frozen on hold or reserved code
        if (!active)
            s_nxt.acc = '0;
        else if (!s_r.ctrl[aof_pkg::CTRL_HOLD] && s_r.tc <= aof_pkg::TC_MAX_SEL)
            s_nxt.acc = s_r.acc + AW'(signed'(tail[DW-1:0])) - AW'(est);
        // Output stage: overload forces full scale before coding
        s_nxt.o_ovr = (tail[DW+1] || tail[DW]) && !stby;
        s_nxt.o_pos = tail[DW+1];
        s_nxt.o_ob  = eff_ob;
        s_nxt.o_par = eff_par;
        if (stby)
            s_nxt.q = '0;
        else if (tail[DW+1])
            s_nxt.q = eff_ob ? {DW{1'b1}} : MAXC;
        else if (tail[DW])
            s_nxt.q = eff_ob ? '0 : MINC;
        else
            s_nxt.q = eff_ob ? {~code[DW-1], code[DW-2:0]} : code;
    end

    // State register
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_r       <= '0;
            s_r.ctrl  <= aof_pkg::CTRL_RST;
            s_r.tc    <= aof_pkg::TC_RST;
        end
        else
            s_r <= s_nxt;
    end

    // Outputs; the clock acts as the double-rate select, as an output DDR cell would
    always_comb
    begin
        avs_waitrequest = (avs_read || avs_write) && !s_r.ack;
        avs_readdata    = s_r.rdata;
        sample_data     = s_r.o_par ? s_r.q : '0;
        for (int i = 0; i < DW/2; i++)
            ddr_pair[i] = s_r.o_par ? 1'b0 : (clk ? s_r.q[2*i+1] : s_r.q[2*i]);
        forwarded_clock_true   = !s_r.o_par && clk;
        forwarded_clock_comp   = !s_r.o_par && !clk;
        // Inverted so the receiver's rising edge falls mid-eye
        forwarded_clock_single = s_r.o_par && !clk;
        data_oe        = oe_s && !stby;
        overrange_flag = s_r.o_ovr;
        standby        = stby;
    end

    // Checks
    default clocking aof_cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    property p_ovr_lat;
        (sample_over_pos || sample_over_neg) |-> ##22 (overrange_flag || $past(stby));
    endproperty
    a_ovr_lat: assert property (p_ovr_lat) else $error("overrange not at latency");

    property p_pos_fs;
        (s_r.o_ovr && s_r.o_pos) |-> (s_r.q == (s_r.o_ob ? {DW{1'b1}} : MAXC));
    endproperty
    a_pos_fs: assert property (p_pos_fs) else $error("positive clip code wrong");

    property p_neg_fs;
        (s_r.o_ovr && !s_r.o_pos) |-> (s_r.q == (s_r.o_ob ? '0 : MINC));
    endproperty
    a_neg_fs: assert property (p_neg_fs) else $error("negative clip code wrong");

    property p_idle_off;
        !s_r.tc_set |-> (est == '0) && (s_r.acc == '0);
    endproperty
    a_idle_off: assert property (p_idle_off) else $error("loop ran before setup");

    property p_hold;
        (active && s_r.ctrl[aof_pkg::CTRL_HOLD]) ##1 active |-> $stable(est);
    endproperty
    a_hold: assert property (p_hold) else $error("estimate moved while held");

    property p_range;
        (est <= LIM_P) && (est >= LIM_N);
    endproperty
    a_range: assert property (p_range) else $error("estimate out of range");

    property p_oe;
        data_oe |-> $past(output_enable_pin, 2);
    endproperty
    a_oe: assert property (p_oe) else $error("buffers on without pin");

    property p_strap;
        (use_strap && strap_s == aof_pkg::STRAP_3_8) [*2] |=> s_r.o_par && !s_r.o_ob;
    endproperty
    a_strap: assert property (p_strap) else $error("strap mode wrong");

    property p_stby;
        stby |=> (s_r.q == '0) && !overrange_flag;
    endproperty
    a_stby: assert property (p_stby) else $error("standby did not blank");

    c_ovr: cover property (sample_over_pos ##22 overrange_flag);
    c_hold: cover property (active && s_r.ctrl[aof_pkg::CTRL_HOLD] && est != '0);
    c_par: cover property (use_strap ##3 s_r.o_par);
endmodule
`default_nettype wire

// File: common/aof_pkg.sv
// Constants shared by the converter output formatter
package aof_pkg;
    // Avalon byte offsets of the control registers
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_TC     = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    // Control register field positions
    localparam int CTRL_EN     = 0;
    localparam int CTRL_HOLD   = 1;
    localparam int CTRL_OB     = 2;
    localparam int CTRL_PAR    = 3;
    localparam int CTRL_STRAP  = 4;
    // Status register field positions
    localparam int STAT_ACT    = 0;
    localparam int STAT_OVR    = 1;
    localparam int STAT_STBY   = 2;
    localparam int STAT_PAR    = 3;
    localparam int STAT_OB     = 4;
    localparam int STAT_EST    = 16;
    // Reset values: correction off, strap in charge
    localparam logic [4:0] CTRL_RST = 5'h10;
    localparam logic [3:0] TC_RST   = 4'h0;
    // Loop time constant: code 0 is 2^20 cycles, one doubling per step
    localparam int TC_BASE_LOG2 = 20;
    localparam logic [3:0] TC_MAX_SEL = 4'hB;
    // Correction range and full scale, in millivolts
    localparam int DC_LIMIT_MV = 10;
    localparam int FS_MVPP     = 1500;
    // Sample pipeline latency in sampling clock cycles
    localparam int LATENCY = 21;
    // Decoded strap levels
    localparam logic [1:0] STRAP_GND  = 2'h0;
    localparam logic [1:0] STRAP_3_8  = 2'h1;
    localparam logic [1:0] STRAP_5_8  = 2'h2;
    localparam logic [1:0] STRAP_AVDD = 2'h3;
    // Full-scale codes on the 14-bit bus
    localparam logic [13:0] OB_POS_FS = 14'h3FFF;
    localparam logic [13:0] TC_POS_FS = 14'h1FFF;
    localparam logic [13:0] OB_NEG_FS = 14'h0000;
    localparam logic [13:0] TC_NEG_FS = 14'h2000;
endpackage

// File: bench/aof_rx_model.sv
// Receiver model that captures the sample stream from the output pins
`timescale 1ns/1ps
`default_nettype none
module aof_rx_model (
    input  wire logic        forwarded_clock_true,
    input  wire logic        forwarded_clock_single,
    input  wire logic [6:0]  ddr_pair,
    input  wire logic [13:0] sample_data,
    input  wire logic        overrange_flag,
    output logic      [13:0] rx_word,
    output logic             rx_ovr
);
    logic [6:0] odd_q; // Odd half kept until the even half arrives

    // One capture process, so each output has a single driver; known start values
    initial
    begin
        rx_word = 14'h0000;
        rx_ovr = 1'b0;
        odd_q = 7'h00;
        forever
        begin
            @(forwarded_clock_true or posedge forwarded_clock_single);
            if (forwarded_clock_single)
            begin
                // Parallel word latched on the rising single-ended clock, mid-data
                // Forwarded clock is fine at this rate; above 200 MSPS a delayed
                // copy of the sampling clock would take its place
                rx_word = sample_data;
                rx_ovr = overrange_flag;
            end
            else
            begin
                // Both true clock edges are used, each sampled mid-phase
                #12;
                if (forwarded_clock_true)
                    odd_q = ddr_pair;
                else
                begin
                    // Even bits stand in the low phase and complete the word
                    for (int i = 0; i < 7; i++)
                    begin
                        rx_word[2*i+1] = odd_q[i];
                        rx_word[2*i] = ddr_pair[i];
                    end
                    rx_ovr = overrange_flag;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: bench/tb_adc_output_offset_formatter.sv
// Self-checking bench for the converter output formatter
`timescale 1ns/1ps
`default_nettype none
module tb_adc_output_offset_formatter;
    typedef struct packed {int due; logic [13:0] d; logic v;} aof_note_t;
    logic               clk, rst_b, sample_over_pos, sample_over_neg;
    logic               fix, run, ob_mode;       // Constant input, checking on, coding
    logic signed [13:0] sample_in;
    logic [1:0]         format_interface_strap;
    logic               output_enable_pin, serial_data_in, serial_select_n;
    logic [3:0]         avs_address, avs_byteenable;
    logic               avs_read, avs_write, avs_waitrequest;
    logic [31:0]        avs_writedata, avs_readdata, rd, rnd;
    logic [13:0]        sample_data, rx_word;
    logic [6:0]         ddr_pair;
    logic               forwarded_clock_true, forwarded_clock_comp, forwarded_clock_single;
    logic               data_oe, overrange_flag, standby, rx_ovr;
    logic [2:0]         fclk_v;                  // All three forwarded clocks
    int                 err_total, checked, cyc;
    aof_note_t          notes[$];                // Expected samples, oldest first
    // Pin rows: select_n, data, oe pin, then expected standby and data_oe
    logic [4:0]         pin_tab [4] = '{5'b11110, 5'b10000, 5'b01101, 5'b10101};

    assign fclk_v = {forwarded_clock_true, forwarded_clock_comp, forwarded_clock_single};

    aof_formatter #(.DW(14)) dut (
        .clk, .rst_b, .sample_in, .sample_over_pos, .sample_over_neg, .format_interface_strap,
        .output_enable_pin, .serial_data_in, .serial_select_n, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .sample_data, .ddr_pair, .forwarded_clock_true, .forwarded_clock_comp,
        .forwarded_clock_single, .data_oe, .overrange_flag, .standby);

    aof_rx_model rx (.forwarded_clock_true, .forwarded_clock_single, .ddr_pair, .sample_data,
        .overrange_flag, .rx_word, .rx_ovr);

    // Sampling clock, 50 ns period
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        if (err_total == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // One Avalon transfer; request held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                       output logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        // Wait as long as it takes; only the run's hang limit ends a lost answer
        do
            @(posedge clk);
        while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // Settle a mode, check it, then run a checked random stream through it
    task automatic stream(input logic ob, input logic par);
        repeat (30) @(posedge clk);
        bus(1'b0, aof_pkg::REG_STATUS, 32'h0, rd);
        chk("mode", 32'(rd[4:3]), 32'({ob, par}));
        ob_mode = ob;
        run <= 1'b1;
        @(negedge clk);
        #10;
        chk("fclk", 32'(fclk_v), par ? 32'h1 : 32'h2);
        chk("idle_bus", 32'(par ? {7'h0, ddr_pair} : sample_data), 32'h0);
        repeat (60) @(posedge clk);
        run <= 1'b0;
        repeat (30) @(posedge clk);
    endtask

    // Random samples with sparse overloads; each checked sample leaves a note
    always @(posedge clk)
    begin
        logic p, n;
        logic [13:0] s, e;
        rnd = xs(rnd);
        s = fix ? 14'h1000 : rnd[13:0];
        p = !fix && rnd[22:20] == 3'h0;
        n = !fix && rnd[25:23] == 3'h0;
        sample_in <= s;
        sample_over_pos <= p;
        sample_over_neg <= n;
        // Positive overload wins when both flags are up
        e = p ? (ob_mode ? aof_pkg::OB_POS_FS : aof_pkg::TC_POS_FS)
          : n ? (ob_mode ? aof_pkg::OB_NEG_FS : aof_pkg::TC_NEG_FS)
          : (ob_mode ? s ^ 14'h2000 : s);
        if (run)
            notes.push_back('{cyc + 23, e, p | n});
    end

    // Received word compared with the oldest note once its cycle comes
    always @(posedge clk)
    begin
        if (notes.size() > 0 && notes[0].due == cyc)
        begin
            chk("sample", 32'(rx_word), 32'(notes[0].d));
            chk("overrange", 32'(rx_ovr), 32'(notes[0].v));
            void'(notes.pop_front());
        end
    end

    // Cycle count and hang limit; the run needs about 32000 cycles
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            err_total++;
            tally_and_finish;
        end
    end

    initial
    begin
        logic [31:0] e1;
        rst_b = 1'b0;
        {sample_over_pos, sample_over_neg, fix, run, ob_mode} = 5'h00;
        sample_in = 14'h0000;
        format_interface_strap = 2'h0;
        {serial_select_n, serial_data_in, output_enable_pin} = 3'b101;
        {avs_read, avs_write} = 2'b00;
        avs_address = 4'h0;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'hF;
        rnd = 32'h00000034;
        err_total = 0;
        checked = 0;
        cyc = 0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        bus(1'b0, aof_pkg::REG_CTRL, 32'h0, rd);
        chk("ctrl", rd, {27'h0, aof_pkg::CTRL_RST});
        bus(1'b0, aof_pkg::REG_TC, 32'h0, rd);
        chk("tc", rd, {28'h0, aof_pkg::TC_RST});
        bus(1'b1, 4'hC, 32'hFFFFFFFF, rd);
        bus(1'b0, 4'hC, 32'h0, rd);
        chk("unmapped", rd, 32'h0);
        // Every strap level, then register control overriding the strap
        for (int m = 0; m < 4; m++)
        begin
            format_interface_strap <= 2'(m);
            stream(m > 1, m == 1 || m == 2);
        end
        for (int k = 0; k < 2; k++)
        begin
            format_interface_strap <= 2'h2 - 2'(k);
            bus(1'b1, aof_pkg::REG_CTRL, k ? 32'h4 : 32'h8, rd);
            stream(k[0], !k[0]);
        end
        // Standby only through the serial data pin with select idle
        bus(1'b1, aof_pkg::REG_CTRL, 32'h10, rd);
        for (int i = 0; i < 4; i++)
        begin
            {serial_select_n, serial_data_in, output_enable_pin} <= pin_tab[i][4:2];
            repeat (5) @(posedge clk);
            chk("stby_oe", 32'({standby, data_oe}), 32'(pin_tab[i][1:0]));
        end
        // Offset loop: idle until programmed, moves, holds, then clamps
        fix <= 1'b1;
        bus(1'b1, aof_pkg::REG_CTRL, 32'h11, rd);
        bus(1'b0, aof_pkg::REG_STATUS, 32'h0, rd);
        chk("loop_idle", 32'(rd[0]), 32'h0);
        bus(1'b1, aof_pkg::REG_TC, 32'h0, rd);
        repeat (600) @(posedge clk);
        bus(1'b0, aof_pkg::REG_STATUS, 32'h0, rd);
        chk("loop_run", 32'({rd[0], rd[31:16] >= 16'h1 && rd[31:16] <= 16'h3}), 32'h3);
        bus(1'b1, aof_pkg::REG_CTRL, 32'h13, rd);
        bus(1'b0, aof_pkg::REG_STATUS, 32'h0, e1);
        repeat (300) @(posedge clk);
        bus(1'b0, aof_pkg::REG_STATUS, 32'h0, rd);
        chk("hold", rd, e1);
        bus(1'b1, aof_pkg::REG_CTRL, 32'h11, rd);
        repeat (30000) @(posedge clk);
        bus(1'b0, aof_pkg::REG_STATUS, 32'h0, rd);
        chk("clamp", 32'(rd[31:16]), 32'h0000006D);
        bus(1'b1, aof_pkg::REG_CTRL, 32'h10, rd);
        bus(1'b0, aof_pkg::REG_STATUS, 32'h0, rd);
        chk("loop_off", 32'(rd[0]), 32'h0);
        tally_and_finish;
    end
endmodule
`default_nettype wire
